// ---- shared/sbel_map.svh ----
// Register offsets, bit positions and reset values of the error logging block.
// Included by bare name; holds definitions only.
`ifndef SBEL_MAP_SVH
`define SBEL_MAP_SVH

`define SBEL_ADR_BER 8'h04
`define SBEL_ADR_FADR 8'h08
`define SBEL_ADR_REAR 8'h0c
`define SBEL_ADR_FAER 8'h2c

`define SBEL_B_ES 31
`define SBEL_B_CC 27
`define SBEL_B_TRIG 26
`define SBEL_B_IPE 24
`define SBEL_B_PE 23
`define SBEL_B_WSE 22
`define SBEL_B_READ_IDENT_DATA_UNACKED 21
`define SBEL_B_WRITE_DATA_UNACKED 20
`define SBEL_B_CRD 19
`define SBEL_B_NRR 18
`define SBEL_B_RSE 17
`define SBEL_B_RER 16
`define SBEL_B_COMMAND_UNACKED 15
`define SBEL_B_TTO 13
`define SBEL_B_NODE_SPECIFIC_SUMMARY 12
`define SBEL_B_STF 10
`define SBEL_B_FAILING_COMMANDER_ID_LSB 4
`define SBEL_B_TIMEOUT_DISABLE 2

`define SBEL_W1C_MASK 32'h0dff_a400
`define SBEL_BER_RESET 32'h0000_0400
`define SBEL_RESERVED_MASK 32'h3200_0800

`endif

// ---- shared/sbel_pkg.sv ----
// Types shared by the error logging block.
// Assumes one clock; all event fields are one-cycle pulses on that clock.
package sbel_pkg;

  // ****************
  // Bus events
  // ****************
  typedef struct packed {
    logic cc_fix;
    logic par_err;
    logic par_ack;
    logic wr_missing;
    logic rid_nak;
    logic wd_nak;
    logic crd_rx;
    logic nrr_exp;
    logic read_order_fault;
    logic read_fault_response;
    logic command_unacked_exp;
    logic grant_exp;
  } sbel_event_type;

  typedef struct packed {
    logic issue;
    logic [31:0] data;
    logic [31:0] ext;
    logic [5:0] id;
  } sbel_cmd_type;

  typedef struct packed {
    logic accept;
    logic [31:0] data;
    logic [5:0] id;
    logic [3:0] cmd;
  } sbel_rsp_type;

  // Levels from the node error summary logic
  typedef struct packed {
    logic node_specific_summary;
    logic internal_err;
    logic pmr_corr;
    logic pmr_uncorr;
    logic io_wr_fail;
    logic io_rd_pe;
  } sbel_node_type;

endpackage

// ---- verilog/sbel_sync.sv ----
// Two flip-flop synchroniser for a level arriving from a pin.
// Assumes the level is slow compared with the clock.
`timescale 1ns/10ps
`default_nettype none

module sbel_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire logic d,
  output logic q
);

  logic meta_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

`default_nettype wire

// ---- verilog/sbel_top.sv ----
// Error capture and logging for a system bus adapter node.
// Assumes events come from bus logic on mclk; trigger_pin is asynchronous.
// Function
// - Bus error bits 29, 28, 25 and 11 read as zero.
// - Bit 27 sets on corrected confirmation error; W1C; feeds summary bit.
// - Bit 26 sets while trigger line is high and holds; write one clears it.
// - Bit 24 sets on parity error while confirmation was ACK.
// - Bit 23 sets on any bus parity error; W1C.
// - Bit 22 sets when incoming write aborts for missing data cycles.
// - Bit 21 on read/ident data NO ACK; bit 20 on write data NO ACK.
// - Bit 19 sets on corrected read data response; W1C.
// - Bit 18 sets when read response times out.
// - Bit 17 on read sequence error; bit 16 on read error response.
// - Bit 15 sets after all command retries fail, together with bit 13.
// - Bit 13 sets on grant timeout, command NO ACK or no read data.
// - Read-only bit 12 mirrors node-specific error summary.
// - Bit 10 resets to one; software clears after self-test passes.
// - Bits 9:4 capture failing commander ID after all reattempts fail.
// - Bit 2 disables timeouts: no abort, no timeout flag.
// - Failing address and extension lock on listed commander errors.
// - Every issued command cycle loads length and address unless locked.
// - Responder address loads on each acknowledged command cycle.
// - Responder address, ID and command lock on listed responder errors.
// - Responder length and address freeze on failure, release when clear.
// - Bit 31 is the OR of all error flags except bit 26.
//
// Local design decision: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "sbel_map.svh"

module sbel_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire sbel_pkg::sbel_event_type ev,
  input wire sbel_pkg::sbel_cmd_type cmd,
  input wire sbel_pkg::sbel_rsp_type rsp,
  input wire sbel_pkg::sbel_node_type node,
  input wire logic trigger_pin,
  output logic timeout_disable,
  output logic [5:0] rsp_failing_id,
  output logic [3:0] rsp_failing_cmd
);

  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr == ofs);
  endfunction

  logic [31:0] flags_q;
  logic [31:0] set_v;
  logic [31:0] clr_v;
  logic [31:0] ber_rd;
  logic [5:0] failing_commander_id_q;
  logic [5:0] cur_id_q;
  logic timeout_disable_q;
  logic [31:0] fadr_q;
  logic [31:0] faer_q;
  logic [31:0] rear_q;
  logic [5:0] rfid_q;
  logic [3:0] rfcmd_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic trig_s;
  logic wr_ber;
  logic fadr_lock;
  logic rear_lock;
  logic cmd_fail;
  logic to_ok;

  // ****************
  // Trigger line
  // ****************
  sbel_sync u_trig_sync (
    .mclk(mclk),
    .rst(rst),
    .d(trigger_pin),
    .q(trig_s)
  );

  // ****************
  // Wishbone slave
  // ****************
  // One wait state: ack in the cycle after the request
  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdat_q <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
      unique case (wb_adr_i)
        `SBEL_ADR_BER: rdat_q <= ber_rd;
        `SBEL_ADR_FADR: rdat_q <= fadr_q;
        `SBEL_ADR_REAR: rdat_q <= rear_q;
        `SBEL_ADR_FAER: rdat_q <= faer_q;
        default: rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign wr_ber = ack_q & wb_cyc_i & wb_stb_i & wb_we_i & hit(wb_adr_i, `SBEL_ADR_BER);

  // ****************
  // Flag setting
  // ****************
  // timeouts gated
  assign to_ok = ~timeout_disable_q;

  always_comb begin
    set_v = 32'h0000_0000;
    set_v[`SBEL_B_CC] = ev.cc_fix;
    set_v[`SBEL_B_TRIG] = trig_s;
    set_v[`SBEL_B_IPE] = ev.par_err & ev.par_ack;
    set_v[`SBEL_B_PE] = ev.par_err;
    set_v[`SBEL_B_WSE] = ev.wr_missing;
    set_v[`SBEL_B_READ_IDENT_DATA_UNACKED] = ev.rid_nak;
    set_v[`SBEL_B_WRITE_DATA_UNACKED] = ev.wd_nak;
    set_v[`SBEL_B_CRD] = ev.crd_rx;
    set_v[`SBEL_B_NRR] = ev.nrr_exp & to_ok;
    set_v[`SBEL_B_RSE] = ev.read_order_fault;
    set_v[`SBEL_B_RER] = ev.read_fault_response;
    set_v[`SBEL_B_COMMAND_UNACKED] = ev.command_unacked_exp & to_ok;
    set_v[`SBEL_B_TTO] = (ev.grant_exp | ev.command_unacked_exp | ev.nrr_exp) & to_ok;
  end

  assign clr_v = wr_ber ? (wb_dat_i & lane_mask(wb_sel_i) & `SBEL_W1C_MASK) : 32'h0000_0000;

  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_q <= `SBEL_BER_RESET;
    end else begin
      flags_q <= ((flags_q & ~clr_v) | set_v) & `SBEL_W1C_MASK;
    end
  end

  // ****************
  // Timeout disable
  // ****************
  always_ff @(posedge mclk) begin
    if (rst) begin
      timeout_disable_q <= 1'b0;
    end else if (wr_ber && wb_sel_i[0]) begin
      timeout_disable_q <= wb_dat_i[`SBEL_B_TIMEOUT_DISABLE];
    end
  end

  assign timeout_disable = timeout_disable_q;

  // ****************
  // Read view of flags
  // ****************
  // reserved bits stay zero; summary mirror; OR of flags
  always_comb begin
    ber_rd = flags_q;
    ber_rd[`SBEL_B_NODE_SPECIFIC_SUMMARY] = node.node_specific_summary;
    ber_rd[`SBEL_B_FAILING_COMMANDER_ID_LSB +: 6] = failing_commander_id_q;
    ber_rd[`SBEL_B_TIMEOUT_DISABLE] = timeout_disable_q;
    ber_rd[`SBEL_B_ES] = |(flags_q & ~(32'h1 << `SBEL_B_TRIG)) | node.node_specific_summary;
  end

  // ****************
  // Commander logging
  // ****************
  // lock sources
  assign fadr_lock = flags_q[`SBEL_B_WRITE_DATA_UNACKED] | flags_q[`SBEL_B_NRR] | flags_q[`SBEL_B_RSE]
    | flags_q[`SBEL_B_RER] | flags_q[`SBEL_B_COMMAND_UNACKED] | flags_q[`SBEL_B_TTO] | node.internal_err;

  assign cmd_fail = set_v[`SBEL_B_WRITE_DATA_UNACKED] | set_v[`SBEL_B_NRR] | set_v[`SBEL_B_RSE]
    | set_v[`SBEL_B_RER] | set_v[`SBEL_B_COMMAND_UNACKED] | set_v[`SBEL_B_TTO];

  always_ff @(posedge mclk) begin
    if (rst) begin
      fadr_q <= 32'h0000_0000;
      faer_q <= 32'h0000_0000;
      cur_id_q <= 6'h00;
    end else if (cmd.issue && !fadr_lock) begin
      fadr_q <= cmd.data;
      faer_q <= cmd.ext;
      cur_id_q <= cmd.id;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      failing_commander_id_q <= 6'h00;
    end else if (cmd_fail && !fadr_lock) begin
      failing_commander_id_q <= cur_id_q;
    end
  end

  // ****************
  // Responder logging
  // ****************
  // lock sources
  assign rear_lock = flags_q[`SBEL_B_WSE] | flags_q[`SBEL_B_READ_IDENT_DATA_UNACKED] | node.pmr_corr
    | node.pmr_uncorr | node.internal_err | node.io_wr_fail | node.io_rd_pe;

  always_ff @(posedge mclk) begin
    if (rst) begin
      rear_q <= 32'h0000_0000;
      rfid_q <= 6'h00;
      rfcmd_q <= 4'h0;
    end else if (rsp.accept && !rear_lock) begin
      rear_q <= rsp.data;
      rfid_q <= rsp.id;
      rfcmd_q <= rsp.cmd;
    end
  end

  assign rsp_failing_id = rfid_q;
  assign rsp_failing_cmd = rfcmd_q;

  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_ber_read;
    wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q && wb_adr_i == `SBEL_ADR_BER;
  endsequence

  sequence s_w1c(int b);
    wr_ber && wb_dat_i[b] && wb_sel_i == 4'hf && !set_v[b];
  endsequence

  property p_reserved;
    s_ber_read |=> (wb_dat_o & `SBEL_RESERVED_MASK) == 32'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  property p_cc;
    ev.cc_fix |=> flags_q[`SBEL_B_CC] && ber_rd[`SBEL_B_ES];
  endproperty
  a_cc: assert property (p_cc) else $error("cc not logged");

  property p_ipe;
    ev.par_err && ev.par_ack |=> flags_q[`SBEL_B_IPE] && flags_q[`SBEL_B_PE];
  endproperty
  a_ipe: assert property (p_ipe) else $error("parity flags missing");

  property p_command_unacked_tto;
    $rose(flags_q[`SBEL_B_COMMAND_UNACKED]) |-> flags_q[`SBEL_B_TTO];
  endproperty
  a_command_unacked_tto: assert property (p_command_unacked_tto) else $error("command_unacked without tto");

  property p_timeout_disable;
    timeout_disable_q && $past(timeout_disable_q) |-> !$rose(flags_q[`SBEL_B_TTO]) && !$rose(flags_q[`SBEL_B_NRR]);
  endproperty
  a_timeout_disable: assert property (p_timeout_disable) else $error("timeout while disabled");

  property p_fadr_lock;
    fadr_lock && cmd.issue |=> $stable(fadr_q) && $stable(faer_q);
  endproperty
  a_fadr_lock: assert property (p_fadr_lock) else $error("fadr moved while locked");

  property p_fadr_load;
    !fadr_lock && cmd.issue |=> fadr_q == $past(cmd.data);
  endproperty
  a_fadr_load: assert property (p_fadr_load) else $error("fadr not loaded");

  property p_rear_load;
    !rear_lock && rsp.accept |=> rear_q == $past(rsp.data) && rfid_q == $past(rsp.id);
  endproperty
  a_rear_load: assert property (p_rear_load) else $error("rear not loaded");

  property p_rear_lock;
    rear_lock && rsp.accept |=> $stable(rear_q) && $stable(rfcmd_q);
  endproperty
  a_rear_lock: assert property (p_rear_lock) else $error("rear moved while locked");

  property p_w1c;
    s_w1c(`SBEL_B_RSE) |=> !flags_q[`SBEL_B_RSE];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  property p_ack;
    s_ber_read |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");

endmodule

`default_nettype wire

// ---- test/sbel_bus_model.sv ----
// Far-side model: bus events, command and response cycles, node levels.
// Assumes one caller at a time; every task starts on a rising edge.
`timescale 1ns/10ps
`default_nettype none

module sbel_bus_model (
  input wire logic mclk,
  output var sbel_pkg::sbel_event_type ev,
  output var sbel_pkg::sbel_cmd_type cmd,
  output var sbel_pkg::sbel_rsp_type rsp,
  output var sbel_pkg::sbel_node_type node,
  output var logic trigger_pin
);
  initial begin
    ev = '0;
    cmd = '0;
    rsp = '0;
    node = '0;
    trigger_pin = 1'b0;
  end

  task automatic pulse(input logic [11:0] e);
    @(posedge mclk);
    ev <= e;
    @(posedge mclk);
    ev <= '0;
  endtask

  // Idle bus shows inverted data, never the last value
  task automatic issue(input logic [31:0] d, input logic [31:0] x, input logic [5:0] i);
    @(posedge mclk);
    cmd <= {1'b1, d, x, i};
    @(posedge mclk);
    cmd <= {1'b0, ~d, ~x, ~i};
  endtask

  task automatic accept(input logic [31:0] d, input logic [5:0] i, input logic [3:0] c);
    @(posedge mclk);
    rsp <= {1'b1, d, i, c};
    @(posedge mclk);
    rsp <= {1'b0, ~d, ~i, ~c};
  endtask

  task automatic levels(input logic [5:0] n, input logic t);
    @(posedge mclk);
    node <= n;
    trigger_pin <= t;
  endtask
endmodule

`default_nettype wire

// ---- test/testbench.sv ----
// Bench: Wishbone register tasks, event table, capture and lock checks.
// Assumes sbel_bus_model stands for the system bus side.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic tdis;
  logic [5:0] rfid;
  logic [3:0] rfcmd;
  logic trig;
  sbel_pkg::sbel_event_type ev;
  sbel_pkg::sbel_cmd_type cmd;
  sbel_pkg::sbel_rsp_type rsp;
  sbel_pkg::sbel_node_type node;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] q;
  logic [31:0] idm = 32'hffff_fc0f;
  logic [11:0] evs [12] = '{12'h800, 12'h600, 12'h400, 12'h100, 12'h080, 12'h040,
    12'h020, 12'h010, 12'h008, 12'h004, 12'h002, 12'h001};
  logic [31:0] bits [12] = '{32'h0800_0000, 32'h0180_0000, 32'h0080_0000, 32'h0040_0000,
    32'h0020_0000, 32'h0010_0000, 32'h0008_0000, 32'h0004_2000, 32'h0002_0000,
    32'h0001_0000, 32'h0000_a000, 32'h0000_2000};

  always #10 mclk = ~mclk;

  sbel_top dut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ev(ev), .cmd(cmd), .rsp(rsp), .node(node), .trigger_pin(trig),
    .timeout_disable(tdis), .rsp_failing_id(rfid), .rsp_failing_cmd(rfcmd));

  sbel_bus_model bus (.mclk(mclk), .ev(ev), .cmd(cmd), .rsp(rsp), .node(node),
    .trigger_pin(trig));

  task automatic end_of_test;
    $display("Compares %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      end_of_test;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 16) chk(32'h0, 32'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h04, '1, 32'h8000_0400);
    rd(8'h08, '1, 32'h0);
    rd(8'h0c, '1, 32'h0);
    rd(8'h10, '1, 32'h0);
    wb(1'b1, 8'h04, 32'h0000_0400);
    rd(8'h04, '1, 32'h0);
    $display("reset values done");
    for (int i = 0; i < 12; i++) begin
      bus.pulse(evs[i]);
      wb(1'b1, 8'h04, 32'h0);
      rd(8'h04, idm, bits[i] | 32'h8000_0000);
      wb(1'b1, 8'h04, bits[i]);
      rd(8'h04, idm, 32'h0);
    end
    $display("flag table done");
    wb(1'b1, 8'h04, 32'h0000_0004);
    bus.pulse(12'h013);
    chk({31'h0, tdis}, 32'h1);
    rd(8'h04, idm, 32'h0000_0004);
    wb(1'b1, 8'h04, 32'h0);
    $display("timeout disable done");
    bus.issue(32'h4123_4567, 32'h0000_0011, 6'h05);
    rd(8'h08, '1, 32'h4123_4567);
    bus.issue(32'h8abc_def0, 32'h0000_0022, 6'h2a);
    bus.pulse(12'h008);
    bus.issue(32'h1111_1111, 32'h0000_0033, 6'h01);
    rd(8'h08, '1, 32'h8abc_def0);
    rd(8'h2c, '1, 32'h0000_0022);
    rd(8'h04, 32'h0000_03f0, 32'h0000_02a0);
    wb(1'b1, 8'h04, 32'h0002_0000);
    bus.issue(32'hc000_0001, 32'h0000_0044, 6'h01);
    rd(8'h08, '1, 32'hc000_0001);
    $display("commander capture done");
    bus.accept(32'h4000_00c0, 6'h03, 4'h9);
    rd(8'h0c, '1, 32'h4000_00c0);
    bus.pulse(12'h100);
    bus.accept(32'h0000_0123, 6'h07, 4'h2);
    rd(8'h0c, '1, 32'h4000_00c0);
    chk({22'h0, rfid, rfcmd}, {22'h0, 6'h03, 4'h9});
    wb(1'b1, 8'h04, 32'h0040_0000);
    bus.accept(32'h0000_0123, 6'h07, 4'h2);
    rd(8'h0c, '1, 32'h0000_0123);
    bus.levels(6'h10, 1'b0);
    bus.accept(32'h0000_0456, 6'h01, 4'h1);
    rd(8'h0c, '1, 32'h0000_0123);
    $display("responder capture done");
    bus.levels(6'h20, 1'b0);
    wb(1'b1, 8'h04, 32'h0000_1000);
    rd(8'h04, idm, 32'h8000_1000);
    bus.levels(6'h00, 1'b1);
    repeat (4) @(posedge mclk);
    bus.levels(6'h00, 1'b0);
    repeat (3) @(posedge mclk);
    rd(8'h04, idm, 32'h0400_0000);
    wb(1'b1, 8'h04, 32'hffff_ffff);
    rd(8'h04, idm, 32'h0000_0004);
    $display("summary, trigger and reserved done");
    end_of_test;
  end
endmodule

`default_nettype wire
